// file: common/uis_pkg.sv
// Constants and types for the interrupt and soft-shutdown block.
// Assumes a receiver and transmitter on the same clock feed its strobes.
// Notes on behaviour
// (R1) Parity flag follows oldest unread word
// (R2) Parity flag is one only when enabled
// (R3) Parity interrupt uses oldest FIFO entry only
// (R4) Data-available while unread or being read
// (R5) Interrupt low while data-available and enabled
// (R6) Activity flag cleared, set, cleared in shutdown
// (R7) Interrupt low on activity when enabled
// (R8) Framing flag from current character, unstored
// (R9) Framing flag set/cleared by stop bit
// (R10) Interrupt low on framing error when enabled
// (R11) Transmit-empty flag and interrupt on emptying
// (R12) Transmit interrupt cleared at 16th clock
// (R13) Shutdown waits for transmitter to drain
// (R14) Oscillator off while shut down
// (R15) Shutdown status set on real entry
// (R16) Entry flushes FIFO, flags, forces T
// (R17) Configuration stays writable while shut down
// (R18) Oscillator restarts at chip-select rising
// (R19) Controller waits, then rewrites configuration
// (R20) Transceiver and UART shutdowns stay independent
// (R21) Interrupt releases once conditions are gone
// (R22) Receive FIFO holds eight words
// (R23) All enabled sources merge onto one line
package uis_pkg;
    localparam int        FIFO_DEPTH    = 8;
    localparam int        DATA_W        = 8;
    localparam int        ENTRY_W       = DATA_W + 1;
    localparam int        BIT_CNT_W     = 5;
    localparam int        CMD_W         = 2;
    localparam logic [CMD_W-1:0]     CMD_READ_DATA  = 2'h0;
    localparam logic [CMD_W-1:0]     CMD_WRITE_DATA = 2'h2;
    localparam logic [BIT_CNT_W-1:0] CNT_CMD_HI     = 5'h0;
    localparam logic [BIT_CNT_W-1:0] CNT_CMD_LO     = 5'h1;
    localparam logic [BIT_CNT_W-1:0] CNT_LAST_PULSE = 5'h10;
    localparam logic [BIT_CNT_W-1:0] CNT_ONE        = 5'h1;
    localparam logic [BIT_CNT_W-1:0] CNT_ZERO       = 5'h0;
    localparam int        PAR_BIT       = DATA_W;
    typedef logic [DATA_W-1:0]  uis_data_t;
    typedef logic [ENTRY_W-1:0] uis_entry_t;
    typedef enum logic [1:0] {UIS_RUN, UIS_DRAIN, UIS_TRANSCEIVER_POWERDOWN_N} uis_state_e;
endpackage

// file: common/uis_fifo_if.sv
// Carrier between the shutdown core and its receive word store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface uis_fifo_if;
    import uis_pkg::*;
    logic       push;
    uis_entry_t push_data;
    logic       pop;
    logic       flush;
    uis_entry_t head;
    logic       empty;
    logic       full;
    modport core (output push, push_data, pop, flush, input head, empty, full);
    modport mem  (input push, push_data, pop, flush, output head, empty, full);
endinterface

// file: rtl/uis_rx_fifo.sv
// Receive word store with a registered head word.
// Assumes pop is only asked while not empty.
`timescale 1ns/1ps
module uis_rx_fifo
    import uis_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    uis_fifo_if.mem   fifo
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] CNT_DEPTH = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W:0] CNT_STEP  = (PTR_W+1)'(1);
    localparam logic [PTR_W-1:0] PTR_STEP = PTR_W'(1);

    uis_entry_t       mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0]   count_r;
    uis_entry_t       head_r;
    logic             empty_r;

    wire              do_push     = fifo.push && (count_r != CNT_DEPTH);
    wire              do_pop      = fifo.pop && !empty_r;
    wire [PTR_W-1:0]  rd_ptr_nxt  = do_pop ? rd_ptr_r + PTR_STEP : rd_ptr_r;
    wire [PTR_W:0]    count_nxt   = count_r + (do_push ? CNT_STEP : '0)
                                  - (do_pop ? CNT_STEP : '0);
    wire              bypass      = do_push && (wr_ptr_r == rd_ptr_nxt);
    wire uis_entry_t  head_nxt    = bypass ? fifo.push_data : mem_r[rd_ptr_nxt];

    always_ff @(posedge CLK) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= fifo.push_data;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            head_r   <= '0;
            empty_r  <= 1'b1;
        end else if (fifo.flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            head_r   <= '0;
            empty_r  <= 1'b1;
        end else begin
            wr_ptr_r <= do_push ? wr_ptr_r + PTR_STEP : wr_ptr_r;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            head_r   <= head_nxt;
            empty_r  <= (count_nxt == '0);
        end
    end

    assign fifo.head  = head_r;
    assign fifo.empty = empty_r;
    assign fifo.full  = (count_r == CNT_DEPTH);
endmodule

// file: rtl/uis_irq_transceiver_powerdown_n.sv
// Interrupt sources, mask gating and UART soft shutdown control.
// Assumes receiver and transmitter strobes on CLK; pins arrive asynchronous.
`timescale 1ns/1ps
module uis_irq_transceiver_powerdown_n
    import uis_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              CS_N,
    input  wire logic              SCLK,
    input  wire logic              DIN,
    input  wire logic              RX_LINE,
    input  wire logic              CTS_N,
    input  wire logic              TRANSCEIVER_POWERDOWN_N,
    input  wire logic              PARITY_ENABLE,
    input  wire logic              PARITY_IRQ_ENABLE,
    input  wire logic              RX_AVAIL_IRQ_ENABLE,
    input  wire logic              ACT_FE_IRQ_ENABLE,
    input  wire logic              TX_EMPTY_IRQ_ENABLE,
    input  wire logic              SHUTDOWN_REQUEST,
    input  wire logic              RX_WORD_VALID,
    input  wire uis_pkg::uis_data_t RX_WORD,
    input  wire logic              RX_PARITY_BIT,
    input  wire logic              STOP_BIT_STROBE,
    input  wire logic              STOP_BIT_VALUE,
    input  wire logic              TX_BUF_EMPTY,
    input  wire logic              TX_SHIFT_IDLE,
    output logic                   IRQ_N,
    output logic                   RX_AVAIL_FLAG,
    output logic                   TX_EMPTY_FLAG,
    output logic                   ACTIVITY_OR_FRAME_ERR_FLAG,
    output logic                   RX_PARITY_FLAG,
    output uis_pkg::uis_data_t     RX_DATA_BITS,
    output logic                   CTS_STATE,
    output logic                   OSC_ENABLE,
    output logic                   SHUTDOWN_STATUS,
    output logic                   FLUSH_RX,
    output logic                   XCVR_ENABLE
);
    import uis_pkg::*;

    // Pin synchronisers
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic sclk_s1_r;
    logic sclk_s2_r;
    logic sclk_s3_r;
    logic din_s1_r;
    logic din_s2_r;
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_s3_r;
    logic cts_s1_r;
    logic cts_s2_r;
    logic xcvr_s1_r;
    logic xcvr_s2_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_s3_r   <= 1'b1;
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            din_s1_r  <= 1'b0;
            din_s2_r  <= 1'b0;
            rx_s1_r   <= 1'b1;
            rx_s2_r   <= 1'b1;
            rx_s3_r   <= 1'b1;
            cts_s1_r  <= 1'b1;
            cts_s2_r  <= 1'b1;
            xcvr_s1_r <= 1'b0;
            xcvr_s2_r <= 1'b0;
        end else begin
            cs_s1_r   <= CS_N;
            cs_s2_r   <= cs_s1_r;
            cs_s3_r   <= cs_s2_r;
            sclk_s1_r <= SCLK;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            din_s1_r  <= DIN;
            din_s2_r  <= din_s1_r;
            rx_s1_r   <= RX_LINE;
            rx_s2_r   <= rx_s1_r;
            rx_s3_r   <= rx_s2_r;
            cts_s1_r  <= CTS_N;
            cts_s2_r  <= cts_s1_r;
            xcvr_s1_r <= TRANSCEIVER_POWERDOWN_N;
            xcvr_s2_r <= xcvr_s1_r;
        end
    end

    wire cs_active = !cs_s2_r;
    wire cs_fall   = cs_s3_r && !cs_s2_r;
    wire cs_rise   = !cs_s3_r && cs_s2_r;
    wire sclk_rise = sclk_s2_r && !sclk_s3_r && cs_active;
    wire rx_edge   = rx_s2_r ^ rx_s3_r;

    // Frame tracking
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic [BIT_CNT_W-1:0] bit_cnt_nxt;
    logic [CMD_W-1:0]     cmd_r;
    logic [CMD_W-1:0]     cmd_nxt;

    wire cnt_full   = (bit_cnt_r == CNT_LAST_PULSE);
    wire last_pulse = sclk_rise && (bit_cnt_r == CNT_LAST_PULSE - CNT_ONE);
    wire cmd_known  = (bit_cnt_r > CNT_CMD_LO);
    wire is_read    = cmd_known && (cmd_r == CMD_READ_DATA);
    wire is_write   = cmd_known && (cmd_r == CMD_WRITE_DATA);

    assign bit_cnt_nxt = cs_fall ? CNT_ZERO :
                         (sclk_rise && !cnt_full) ? bit_cnt_r + CNT_ONE : bit_cnt_r;

    assign cmd_nxt = (sclk_rise && bit_cnt_r == CNT_CMD_HI) ? {din_s2_r, cmd_r[0]} :
                     (sclk_rise && bit_cnt_r == CNT_CMD_LO) ? {cmd_r[1], din_s2_r} :
                     cmd_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bit_cnt_r <= CNT_ZERO;
            cmd_r     <= CMD_READ_DATA;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            cmd_r     <= cmd_nxt;
        end
    end

    // Shutdown sequencing
    uis_state_e state_r;
    uis_state_e state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            UIS_RUN: begin
                if (SHUTDOWN_REQUEST) begin
                    state_nxt = UIS_DRAIN;
                end
            end
            UIS_DRAIN: begin
                if (!SHUTDOWN_REQUEST) begin
                    state_nxt = UIS_RUN;
                end else if (TX_BUF_EMPTY && TX_SHIFT_IDLE) begin // R13
                    state_nxt = UIS_TRANSCEIVER_POWERDOWN_N;
                end
            end
            UIS_TRANSCEIVER_POWERDOWN_N: begin
                if (!SHUTDOWN_REQUEST && cs_rise) begin // R18
                    state_nxt = UIS_RUN;
                end
            end
            default: begin
                state_nxt = UIS_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= UIS_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    wire in_transceiver_powerdown_n    = (state_r == UIS_TRANSCEIVER_POWERDOWN_N);
    wire transceiver_powerdown_n_enter = (state_r != UIS_TRANSCEIVER_POWERDOWN_N) && (state_nxt == UIS_TRANSCEIVER_POWERDOWN_N);
    wire transceiver_powerdown_n_exit  = in_transceiver_powerdown_n && (state_nxt != UIS_TRANSCEIVER_POWERDOWN_N);

    // Receive word store
    uis_fifo_if fifo_if ();

    uis_rx_fifo #(
        .DEPTH   (FIFO_DEPTH)
    ) u_rx_fifo (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .fifo    (fifo_if.mem)
    ); // R22

    wire read_done = cs_rise && is_read && cnt_full;

    assign fifo_if.push      = RX_WORD_VALID && !in_transceiver_powerdown_n;
    assign fifo_if.push_data = {RX_PARITY_BIT && PARITY_ENABLE, RX_WORD}; // R2
    assign fifo_if.pop       = read_done && !fifo_if.empty;
    assign fifo_if.flush     = transceiver_powerdown_n_enter; // R16

    wire reading     = cs_active && is_read && !fifo_if.empty;
    wire avail_nxt   = !fifo_if.empty || reading; // R4
    wire par_flag    = !fifo_if.empty && fifo_if.head[PAR_BIT] && PARITY_ENABLE; // R1 R3

    // Activity / framing flag, shared register
    logic act_fe_r;
    logic act_fe_nxt;

    assign act_fe_nxt = (transceiver_powerdown_n_enter || transceiver_powerdown_n_exit) ? 1'b0 :            // R6 R16
                        (in_transceiver_powerdown_n && rx_edge) ? 1'b1 :                // R6
                        (!in_transceiver_powerdown_n && STOP_BIT_STROBE) ? !STOP_BIT_VALUE : // R8 R9
                        act_fe_r;

    // Transmit-empty interrupt source
    logic tx_empty_d_r;
    logic tx_src_r;
    logic tx_src_nxt;

    wire tx_flag      = TX_BUF_EMPTY || in_transceiver_powerdown_n; // R11 R16
    wire tx_became    = tx_flag && !tx_empty_d_r;
    wire tx_src_clr   = (last_pulse && (is_read || is_write)) || (cs_rise && is_read); // R12

    assign tx_src_nxt = tx_became ? 1'b1 :       // R11
                        tx_src_clr ? 1'b0 :      // R12
                        tx_src_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            act_fe_r     <= 1'b0;
            tx_empty_d_r <= 1'b1;
            tx_src_r     <= 1'b0;
        end else begin
            act_fe_r     <= act_fe_nxt;
            tx_empty_d_r <= tx_flag;
            tx_src_r     <= tx_src_nxt;
        end
    end

    // Source gating onto one line
    wire irq_par   = par_flag && PARITY_IRQ_ENABLE;                // R3
    wire irq_avail = avail_nxt && RX_AVAIL_IRQ_ENABLE;             // R5
    wire irq_actfe = act_fe_r && ACT_FE_IRQ_ENABLE;                // R7 R10
    wire irq_tx    = tx_src_r && TX_EMPTY_IRQ_ENABLE;              // R11
    wire irq_any   = irq_par || irq_avail || irq_actfe || irq_tx;  // R21 R23

    // Output registers
    logic      irq_n_r;
    logic      avail_r;
    logic      tx_flag_r;
    logic      par_r;
    uis_data_t data_r;
    logic      cts_r;
    logic      osc_r;
    logic      transceiver_powerdown_n_r;
    logic      xcvr_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_n_r   <= 1'b1;
            avail_r   <= 1'b0;
            tx_flag_r <= 1'b1;
            par_r     <= 1'b0;
            data_r    <= '0;
            cts_r     <= 1'b0;
            osc_r     <= 1'b1;
            transceiver_powerdown_n_r    <= 1'b0;
            xcvr_r    <= 1'b0;
        end else begin
            irq_n_r   <= !irq_any;                                 // R23
            avail_r   <= avail_nxt;                                // R4
            tx_flag_r <= tx_flag;                                  // R11
            par_r     <= par_flag;                                 // R1
            data_r    <= fifo_if.empty ? '0 : fifo_if.head[DATA_W-1:0]; // R16
            cts_r     <= !cts_s2_r;                                // R17
            osc_r     <= (state_nxt != UIS_TRANSCEIVER_POWERDOWN_N);                  // R14 R18
            transceiver_powerdown_n_r    <= (state_nxt == UIS_TRANSCEIVER_POWERDOWN_N);                  // R15
            xcvr_r    <= xcvr_s2_r;                                // R20
        end
    end

    assign IRQ_N                      = irq_n_r;
    assign RX_AVAIL_FLAG              = avail_r;
    assign TX_EMPTY_FLAG              = tx_flag_r;
    assign ACTIVITY_OR_FRAME_ERR_FLAG = act_fe_r;
    assign RX_PARITY_FLAG             = par_r;
    assign RX_DATA_BITS               = data_r;
    assign CTS_STATE                  = cts_r;
    assign OSC_ENABLE                 = osc_r;
    assign SHUTDOWN_STATUS            = transceiver_powerdown_n_r;
    assign FLUSH_RX                   = transceiver_powerdown_n_enter;
    assign XCVR_ENABLE                = xcvr_r;
endmodule

// file: bench/uis_irq_transceiver_powerdown_n_chk.sv
// Checker for interrupt gating and soft shutdown of the top module.
// Assumes it sees the top module's ports only, through bind.
`timescale 1ns/1ps
module uis_irq_transceiver_powerdown_n_chk
    import uis_pkg::*;
(
    input wire logic               CLK,
    input wire logic               RESET_N,
    input wire logic               CS_N,
    input wire logic               PARITY_IRQ_ENABLE,
    input wire logic               RX_AVAIL_IRQ_ENABLE,
    input wire logic               ACT_FE_IRQ_ENABLE,
    input wire logic               TX_EMPTY_IRQ_ENABLE,
    input wire logic               SHUTDOWN_REQUEST,
    input wire logic               TX_BUF_EMPTY,
    input wire logic               TX_SHIFT_IDLE,
    input wire logic               FLUSH_RX,
    input wire logic               IRQ_N,
    input wire logic               RX_AVAIL_FLAG,
    input wire logic               TX_EMPTY_FLAG,
    input wire logic               ACTIVITY_OR_FRAME_ERR_FLAG,
    input wire logic               RX_PARITY_FLAG,
    input wire uis_pkg::uis_data_t RX_DATA_BITS,
    input wire logic               OSC_ENABLE,
    input wire logic               SHUTDOWN_STATUS
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    a_avail_irq: assert property ((RX_AVAIL_FLAG && RX_AVAIL_IRQ_ENABLE) [*2] |-> !IRQ_N)
        else $error("irq high with data waiting");
    a_act_irq: assert property ((ACTIVITY_OR_FRAME_ERR_FLAG && ACT_FE_IRQ_ENABLE) [*2] |-> !IRQ_N)
        else $error("irq high with activity or framing flag");
    a_parity_irq: assert property ((RX_PARITY_FLAG && PARITY_IRQ_ENABLE) [*2] |-> !IRQ_N)
        else $error("irq high with parity flag");
    a_irq_merge: assert property ((!PARITY_IRQ_ENABLE && !RX_AVAIL_IRQ_ENABLE && !ACT_FE_IRQ_ENABLE
        && !TX_EMPTY_IRQ_ENABLE) [*2] |-> IRQ_N)
        else $error("irq low with every source masked");
    a_transceiver_powerdown_n_clear: assert property (SHUTDOWN_STATUS [*3] |-> !RX_AVAIL_FLAG && !RX_PARITY_FLAG
        && RX_DATA_BITS == 8'h00 && TX_EMPTY_FLAG)
        else $error("receive state not cleared in shutdown");
    a_osc_off: assert property (SHUTDOWN_STATUS |-> !OSC_ENABLE)
        else $error("oscillator running in shutdown");
    a_drain_wait: assert property ($rose(SHUTDOWN_STATUS) |-> $past(TX_SHIFT_IDLE)
        && $past(TX_BUF_EMPTY))
        else $error("shutdown entered while transmitter busy");
    a_flush_entry: assert property ($rose(SHUTDOWN_STATUS) |-> $past(FLUSH_RX))
        else $error("receive store not flushed on shutdown entry");
    a_exit_cs: assert property ($fell(SHUTDOWN_STATUS) |-> !SHUTDOWN_REQUEST && CS_N)
        else $error("shutdown left without request low and select high");
endmodule
bind uis_irq_transceiver_powerdown_n uis_irq_transceiver_powerdown_n_chk uis_irq_transceiver_powerdown_n_chk_i (.*);

// file: bench/uis_host_model.sv
// Serial master model driving chip select, serial clock and data.
// Assumes the block samples these pins on its own unrelated clock.
`timescale 1ns/1ps
module uis_host_model (
    output logic CS_N,
    output logic SCLK,
    output logic DIN
);
    initial begin
        CS_N = 1'h1;
        SCLK = 1'h0;
        DIN  = 1'h0;
    end
    // Frame of n pulses, command bits first; clock idle outside frames
    task automatic frame(input logic [1:0] cmd, input int n);
        CS_N = 1'h0;
        for (int i = 0; i < n; i++) begin
            DIN = (i < 2) ? cmd[1-i] : 1'h0;
            #80;
            SCLK = 1'h1;
            #80;
            SCLK = 1'h0;
        end
        #80;
        CS_N = 1'h1;
        // Released data line shows the inverse of its last value
        DIN = ~DIN;
        #400;
    endtask
endmodule

// file: bench/uis_irq_transceiver_powerdown_n_bench.sv
// Self-checking bench for interrupt sources, masks and soft shutdown.
// Assumes the serial master model drives chip select, clock and data.
`timescale 1ns/1ps
module uis_irq_transceiver_powerdown_n_bench;
    import uis_pkg::*;
    logic       clk = 1'h0, rst_n = 1'h0, rx_line = 1'h1, cts_n = 1'h1, xpd_n = 1'h1;
    logic       pe = 1'h0, pm = 1'h0, rm = 1'h0, am = 1'h0, tm = 1'h0, sd_req = 1'h0;
    logic       rx_vld = 1'h0, rx_par = 1'h0, stb = 1'h0, stb_v = 1'h1;
    logic       tx_emp = 1'h1, tx_idle = 1'h1;
    logic       cs_n, sclk, din, irq_n, avail, t_flag, act, par_flag, cts, osc, sd_st, xcvr;
    uis_data_t  rx_word = 8'h00, data, w;
    int         fail_count = 0, cmp_count = 0;
    // Row: parity enable, parity mask, data mask, parity in, parity flag, irq_n
    logic [5:0] rows [5] = '{6'h36, 6'h31, 6'h15, 6'h0c, 6'h27};
    always #2 clk = ~clk;
    uis_host_model uis_host_model_i (.CS_N(cs_n), .SCLK(sclk), .DIN(din));
    uis_irq_transceiver_powerdown_n uis_irq_transceiver_powerdown_n_i (
        .CLK(clk), .RESET_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .RX_LINE(rx_line),
        .CTS_N(cts_n), .TRANSCEIVER_POWERDOWN_N(xpd_n), .PARITY_ENABLE(pe),
        .PARITY_IRQ_ENABLE(pm), .RX_AVAIL_IRQ_ENABLE(rm), .ACT_FE_IRQ_ENABLE(am),
        .TX_EMPTY_IRQ_ENABLE(tm), .SHUTDOWN_REQUEST(sd_req), .RX_WORD_VALID(rx_vld),
        .RX_WORD(rx_word), .RX_PARITY_BIT(rx_par), .STOP_BIT_STROBE(stb),
        .STOP_BIT_VALUE(stb_v), .TX_BUF_EMPTY(tx_emp), .TX_SHIFT_IDLE(tx_idle),
        .IRQ_N(irq_n), .RX_AVAIL_FLAG(avail), .TX_EMPTY_FLAG(t_flag), .RX_DATA_BITS(data),
        .ACTIVITY_OR_FRAME_ERR_FLAG(act), .RX_PARITY_FLAG(par_flag), .CTS_STATE(cts),
        .OSC_ENABLE(osc), .SHUTDOWN_STATUS(sd_st), .FLUSH_RX(), .XCVR_ENABLE(xcvr)
    );
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Back-to-back words, parity from the low bits of base and index
    task automatic push(input uis_data_t base, input int n);
        rx_vld = 1'h1;
        for (int i = 0; i < n; i++) begin
            rx_word = base + 8'(i);
            rx_par = base[0] ^ i[0];
            tick(1);
        end
        rx_vld = 1'h0;
    endtask
    task automatic strobe(input logic v);
        stb_v = v;
        stb = 1'h1;
        tick(1);
        stb = 1'h0;
        tick(2);
    endtask
    task automatic rd(input logic [1:0] c, input int n);
        uis_host_model_i.frame(c, n);
        tick(1);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        test_done();
    end
    initial begin
        tick(16);
        rst_n = 1'h1;
        tick(2);
        foreach (rows[k]) begin
            {pe, pm, rm} = rows[k][5:3];
            w = 8'ha0 + 8'(2 * k) + 8'(rows[k][2]);
            push(w, 1);
            tick(3);
            chk("data", w, data);
            chk("avail", 1'h1, avail);
            chk("parity", rows[k][1], par_flag);
            chk("irq", rows[k][0], irq_n);
            rd(CMD_READ_DATA, 16);
            chk("avail read", 1'h0, avail);
            chk("irq free", 1'h1, irq_n);
        end
        push(8'h55, 1);
        tick(3);
        rst_n = 1'h0;
        #1;
        chk("rst irq", 1'h1, irq_n);
        chk("rst avail", 1'h0, avail);
        chk("rst osc", 1'h1, osc);
        tick(16);
        rst_n = 1'h1;
        tick(2);
        {pe, pm, rm} = 3'h4;
        push(8'h10, 9);
        tick(3);
        rd(CMD_READ_DATA, 8);
        chk("short frame", 8'h10, data);
        for (int i = 0; i < 8; i++) begin
            chk("fifo data", 8'h10 + 8'(i), data);
            chk("fifo parity", i[0], par_flag);
            rd(CMD_READ_DATA, 16);
        end
        chk("fifo empty", 1'h0, avail);
        tx_emp = 1'h0;
        rd(CMD_WRITE_DATA, 16);
        tm = 1'h1;
        tick(3);
        chk("t full", 1'h0, t_flag);
        chk("irq t idle", 1'h1, irq_n);
        tx_emp = 1'h1;
        tick(3);
        chk("irq t", 1'h0, irq_n);
        rd(CMD_WRITE_DATA, 16);
        chk("irq t clr", 1'h1, irq_n);
        chk("t poll", 1'h1, t_flag);
        tm = 1'h0;
        am = 1'h1;
        strobe(1'h0);
        chk("fe set", 1'h1, act);
        chk("fe irq", 1'h0, irq_n);
        push(8'h77, 1);
        strobe(1'h1);
        chk("fe clr", 1'h0, act);
        strobe(1'h0);
        tx_idle = 1'h0;
        sd_req = 1'h1;
        tick(20);
        chk("drain", 1'h0, sd_st);
        tx_idle = 1'h1;
        for (int i = 0; i < 50 && sd_st !== 1'h1; i++) tick(1);
        tick(3);
        chk("sd status", 1'h1, sd_st);
        chk("osc off", 1'h0, osc);
        chk("flush", 1'h0, avail);
        chk("sd parity", 1'h0, par_flag);
        chk("sd t", 1'h1, t_flag);
        chk("sd act", 1'h0, act);
        rx_line = 1'h0;
        cts_n = 1'h0;
        xpd_n = 1'h0;
        tick(6);
        chk("act set", 1'h1, act);
        chk("act irq", 1'h0, irq_n);
        chk("cts", 1'h1, cts);
        chk("xcvr", 1'h0, xcvr);
        chk("sd kept", 1'h1, sd_st);
        sd_req = 1'h0;
        tick(20);
        chk("await cs", 1'h1, sd_st);
        rd(CMD_READ_DATA, 16);
        chk("osc on", 1'h1, osc);
        chk("sd exit", 1'h0, sd_st);
        chk("act exit", 1'h0, act);
        tick(50);
        test_done();
    end
endmodule
